// >>> src/acq_pkg.sv
// Shared constants for the acquisition control block.
// Assumes a 125 MHz system clock and a plain register port.
package acq_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned RES_W = 12;
	localparam logic [3:0] OFS_CMD1 = 4'h0;
	localparam logic [3:0] OFS_MUXGAIN = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_FIFO = 4'h3;
	localparam logic [3:0] OFS_CONVERT = 4'h4;
	localparam logic [3:0] OFS_CLEAR = 4'h5;
	localparam logic [3:0] OFS_START = 4'h6;
	localparam logic [3:0] OFS_INTERVAL = 4'h7;
	localparam logic [3:0] OFS_COUNT_LO = 4'h8;
	localparam logic [3:0] OFS_COUNT_HI = 4'h9;
	localparam logic [3:0] OFS_RESULT = 4'hA;
	localparam int unsigned GAIN_HI = 7;
	localparam int unsigned GAIN_LO = 6;
	localparam int unsigned CHAN_HI = 3;
	localparam int unsigned CMD_ENABLE = 0;
	localparam int unsigned CMD_FMT_N = 1;
	localparam int unsigned CMD_CASCADE = 2;
	localparam int unsigned CMD_EXTERNAL_CONVERT_N = 3;
	localparam int unsigned CMD_PRETRIG = 4;
	localparam int unsigned CMD_EXT_TB = 5;
	localparam int unsigned ST_AVAIL = 13;
	localparam int unsigned ST_OVERFLOW = 12;
	localparam int unsigned ST_OVERRUN = 11;
	localparam int unsigned ST_BUSY = 10;
	localparam int unsigned ST_ACTIVE = 9;
	localparam int unsigned CONV_LIMIT_NS = 10000;
	localparam int unsigned CONV_LIMIT_CYC = CONV_LIMIT_NS * CLK_MHZ / 1000;
	localparam int unsigned FIFO_DEPTH = 512;
	localparam int unsigned TB_1MHZ_DIV = CLK_MHZ;
	localparam logic [DATA_W-1:0] CMD1_RST = 16'h0000;
	localparam logic [DATA_W-1:0] INTERVAL_RST = 16'h0002;
	localparam logic [DATA_W-1:0] COUNT_RST = 16'h0002;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_RUN} seq_state_t;
endpackage

// >>> src/result_fifo_if.sv
// Push/pop signals between the control block and its result store.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface result_fifo_if #(parameter int W = 12, parameter int AW = 9);
	logic push;
	logic [W-1:0] push_data;
	logic pop;
	logic flush;
	logic [W-1:0] head;
	logic empty;
	logic full;
	modport ctrl(output push, output push_data, output pop, output flush,
		input head, input empty, input full);
	modport store(input push, input push_data, input pop, input flush,
		output head, output empty, output full);
endinterface
`default_nettype wire

// >>> src/result_fifo.sv
// Result store: flip-flop FIFO, drop on push when full.
// Assumes the controller never pops while empty.
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
	parameter int W = 12,
	parameter int AW = 9
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	result_fifo_if.store fp
);
	localparam int DEPTH = 1 << AW;
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] cnt_r;
	wire do_push = fp.push && !fp.full;
	wire do_pop = fp.pop && !fp.empty;
	assign fp.empty = (cnt_r == '0);
	assign fp.full = (cnt_r == (AW+1)'(DEPTH));
	assign fp.head = mem_r[rd_ptr_r];
	always_ff @(posedge sys_clk) begin
		if (do_push && clk_en) begin
			mem_r[wr_ptr_r] <= fp.push_data;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (fp.flush) begin
				wr_ptr_r <= '0;
				rd_ptr_r <= '0;
				cnt_r <= '0;
			end else begin
				if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
				if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
				cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
			end
		end
	end
endmodule
`default_nettype wire

// >>> src/adc_acquisition_control.sv
// Analog input acquisition control: mux/gain, conversion start, result FIFO,
// output format, and sequenced multi-conversion with interval and sample counters.
// Assumes the converter answers conv_start with conv_done plus data, and that
// the trigger pins are already synchronous to sys_clk.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module adc_acquisition_control
	import acq_pkg::*;
#(
	parameter int FIFO_AW = 9,
	parameter int TB_DIV = acq_pkg::TB_1MHZ_DIV
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [acq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [acq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [acq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic external_convert_n,
	input wire logic sequence_start_trigger_n,
	input wire logic pretrigger_stop_input,
	input wire logic external_timebase_input,
	output logic [1:0] gain_sel,
	output logic [3:0] channel_sel,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [acq_pkg::RES_W-1:0] conv_data,
	output logic result_available_flag
);
	import acq_pkg::*;

	result_fifo_if #(.W(RES_W), .AW(FIFO_AW)) fbus ();

	result_fifo #(.W(RES_W), .AW(FIFO_AW)) u_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.clk_en(clk_en),
		.fp(fbus.store)
	);

	logic [DATA_W-1:0] cmd1_r;
	logic [7:0] muxgain_r;
	logic [DATA_W-1:0] interval_r;
	logic [DATA_W-1:0] count_lo_r;
	logic [DATA_W-1:0] count_hi_r;
	logic [DATA_W-1:0] rdata_r;
	logic overflow_r;
	logic overrun_r;
	logic busy_r;
	logic [15:0] busy_cnt_r;
	logic external_convert_n_d_r;
	logic start_d_r;
	logic stop_d_r;
	logic tbsrc_d_r;
	logic [15:0] tb_cnt_r;
	logic [16:0] ival_cnt_r;
	logic [31:0] samp_cnt_r;
	logic counting_r;
	seq_state_t seq_r;
	seq_state_t seq_nxt;

	// Address decode
	wire wr_cmd1 = reg_wr && (reg_addr == OFS_CMD1);
	wire wr_mux = reg_wr && (reg_addr == OFS_MUXGAIN);
	wire wr_conv = reg_wr && (reg_addr == OFS_CONVERT);
	wire wr_clear = reg_wr && (reg_addr == OFS_CLEAR);
	wire wr_start = reg_wr && (reg_addr == OFS_START);
	wire wr_ival = reg_wr && (reg_addr == OFS_INTERVAL);
	wire wr_clo = reg_wr && (reg_addr == OFS_COUNT_LO);
	wire wr_chi = reg_wr && (reg_addr == OFS_COUNT_HI);
	wire rd_fifo = reg_rd && (reg_addr == OFS_FIFO);

	wire acq_en = cmd1_r[CMD_ENABLE];
	wire fmt_unsigned = cmd1_r[CMD_FMT_N];
	wire cascade = cmd1_r[CMD_CASCADE];
	wire use_ext = cmd1_r[CMD_EXTERNAL_CONVERT_N];
	wire pretrig = cmd1_r[CMD_PRETRIG];

	// Falling edges of active-low pins; rising edges of the others
	wire ext_fall = external_convert_n_d_r && !external_convert_n;
	wire start_fall = start_d_r && !sequence_start_trigger_n;
	wire stop_rise = !stop_d_r && pretrigger_stop_input;
	wire tbsrc_rise = !tbsrc_d_r && external_timebase_input;

	// Interval timebase: internal 1 MHz tick or external source edges
	wire tb_int_tick = (tb_cnt_r == 16'(TB_DIV - 1));
	wire tb_tick = cmd1_r[CMD_EXT_TB] ? tbsrc_rise : tb_int_tick;

	// Interval of 0 stands for 65536
	function automatic logic [16:0] interval_len(input logic [15:0] v);
		interval_len = (v == 16'h0000) ? 17'h10000 : {1'b0, v};
	endfunction

	function automatic logic [31:0] sample_total(input logic casc,
		input logic [15:0] lo, input logic [15:0] hi);
		if (!casc) begin
			sample_total = (lo == 16'h0000) ? 32'h0001_0000 : {16'h0000, lo};
		end else begin
			sample_total = {hi, lo};
		end
	endfunction

	wire seq_run = (seq_r == SEQ_RUN);
	wire ival_pulse = seq_run && !use_ext && tb_tick && (ival_cnt_r == 17'h00001);
	wire seq_pulse = seq_run && (use_ext ? ext_fall : ival_pulse);
	wire seq_trig = wr_start || start_fall;
	wire samp_last = seq_pulse && counting_r && (samp_cnt_r == 32'h0000_0001);

	// Pin single starts only outside a running sequence; register starts at any time
	wire single_start = wr_conv || (!seq_run && ext_fall);
	wire any_start = single_start || seq_pulse;
	wire overrun_set = any_start && busy_r;
	wire launch = any_start && !busy_r;

	// Result formatting
	wire [RES_W-1:0] head = fbus.head;
	wire [DATA_W-1:0] fmt_u = {4'h0, head};
	wire [RES_W-1:0] head_s = head ^ {1'b1, {(RES_W-1){1'b0}}};
	wire [DATA_W-1:0] fmt_s = {{4{head_s[RES_W-1]}}, head_s};
	wire [DATA_W-1:0] fifo_word = fmt_unsigned ? fmt_u : fmt_s;
	wire [DATA_W-1:0] status_word = {2'b00, !fbus.empty, overflow_r, overrun_r, busy_r,
		seq_run, 9'h000};

	wire [DATA_W-1:0] rd_mux =
		(reg_addr == OFS_STATUS) ? status_word :
		(reg_addr == OFS_FIFO) ? fifo_word :
		(reg_addr == OFS_CMD1) ? cmd1_r :
		(reg_addr == OFS_MUXGAIN) ? {8'h00, muxgain_r} :
		(reg_addr == OFS_INTERVAL) ? interval_r :
		(reg_addr == OFS_COUNT_LO) ? count_lo_r :
		(reg_addr == OFS_COUNT_HI) ? count_hi_r : 16'h0000;

	assign fbus.push = conv_done && busy_r;
	assign fbus.push_data = conv_data;
	assign fbus.pop = rd_fifo && !fbus.empty;
	assign fbus.flush = wr_clear;
	assign reg_rdata = rdata_r;
	assign gain_sel = muxgain_r[GAIN_HI:GAIN_LO];
	assign channel_sel = muxgain_r[CHAN_HI:0];
	assign conv_start = launch && clk_en;
	assign result_available_flag = !fbus.empty;

	// Sequencer
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SEQ_IDLE: begin
				if (acq_en) seq_nxt = SEQ_ARMED;
			end
			SEQ_ARMED: begin
				if (!acq_en) seq_nxt = SEQ_IDLE;
				else if (seq_trig) seq_nxt = SEQ_RUN;
			end
			SEQ_RUN: begin
				// Errors halt acquisition so no stale data follows a gap
				if (!acq_en || wr_clear) seq_nxt = SEQ_IDLE;
				else if (samp_last || overflow_r || overrun_r) seq_nxt = SEQ_ARMED;
			end
			default: seq_nxt = SEQ_IDLE;
		endcase
	end

	// Control registers keep their value until software writes them again
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmd1_r <= CMD1_RST;
		end else if (clk_en && wr_cmd1) begin
			cmd1_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			muxgain_r <= 8'h00;
		end else if (clk_en && wr_mux) begin
			muxgain_r <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			interval_r <= INTERVAL_RST;
		end else if (clk_en && wr_ival) begin
			interval_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count_lo_r <= COUNT_RST;
		end else if (clk_en && wr_clo) begin
			count_lo_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count_hi_r <= 16'h0000;
		end else if (clk_en && wr_chi) begin
			count_hi_r <= reg_wdata;
		end
	end

	// Read data is zero outside the cycle after a read, so no stale word lingers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_r <= 16'h0000;
		end else if (clk_en) begin
			rdata_r <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// Pin history resets to each idle level, so no false edge follows reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			external_convert_n_d_r <= 1'b1;
			start_d_r <= 1'b1;
			stop_d_r <= 1'b0;
			tbsrc_d_r <= 1'b0;
		end else if (clk_en) begin
			external_convert_n_d_r <= external_convert_n;
			start_d_r <= sequence_start_trigger_n;
			stop_d_r <= pretrigger_stop_input;
			tbsrc_d_r <= external_timebase_input;
		end
	end

	// Error flags: a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			overflow_r <= 1'b0;
		end else if (clk_en) begin
			overflow_r <= (fbus.push && fbus.full) || (overflow_r && !wr_clear);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			overrun_r <= 1'b0;
		end else if (clk_en) begin
			overrun_r <= overrun_set || (overrun_r && !wr_clear);
		end
	end

	// Conversion busy window, bounded so a silent converter cannot hang it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			busy_cnt_r <= 16'h0000;
		end else if (clk_en) begin
			if (launch) begin
				busy_r <= 1'b1;
				busy_cnt_r <= 16'(CONV_LIMIT_CYC - 1);
			end else if (busy_r) begin
				if (conv_done || busy_cnt_r == 16'h0000) busy_r <= 1'b0;
				busy_cnt_r <= busy_cnt_r - 16'h0001;
			end
		end
	end

	// Reload whenever no run continues, so a new trigger needs no reprogramming
	wire seq_reload = (seq_r != SEQ_RUN) || (seq_nxt != SEQ_RUN);
	wire ival_step = !use_ext && tb_tick;
	wire [15:0] tb_cnt_nxt = tb_int_tick ? 16'h0000 : tb_cnt_r + 16'h0001;
	wire [16:0] ival_cnt_nxt =
		seq_reload ? interval_len(interval_r) :
		!ival_step ? ival_cnt_r :
		(ival_cnt_r == 17'h00001) ? interval_len(interval_r) :
		ival_cnt_r - 17'h00001;
	wire [31:0] samp_cnt_nxt =
		seq_reload ? sample_total(cascade, count_lo_r, count_hi_r) :
		(seq_pulse && counting_r) ? samp_cnt_r - 32'h0000_0001 :
		samp_cnt_r;
	wire counting_nxt = seq_reload ? !pretrig : (counting_r || stop_rise);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			seq_r <= SEQ_IDLE;
		end else if (clk_en) begin
			seq_r <= seq_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tb_cnt_r <= 16'h0000;
		end else if (clk_en) begin
			tb_cnt_r <= tb_cnt_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ival_cnt_r <= 17'h00000;
		end else if (clk_en) begin
			ival_cnt_r <= ival_cnt_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			samp_cnt_r <= 32'h0000_0000;
		end else if (clk_en) begin
			samp_cnt_r <= samp_cnt_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			counting_r <= 1'b0;
		end else if (clk_en) begin
			counting_r <= counting_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> verif/adc_acquisition_control_assertions.sv
// Checker: port-level properties of the acquisition control block.
// Assumes a converter that answers each launch well inside the time-out.
`timescale 1ns/1ns
`default_nettype none
module adc_acq_checker
	import acq_pkg::*;
#(
	parameter int FIFO_AW = 9,
	parameter int TB_DIV = 125
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [acq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [acq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [acq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic external_convert_n,
	input wire logic sequence_start_trigger_n,
	input wire logic pretrigger_stop_input,
	input wire logic external_timebase_input,
	input wire logic [1:0] gain_sel,
	input wire logic [3:0] channel_sel,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [acq_pkg::RES_W-1:0] conv_data,
	input wire logic result_available_flag
);
	localparam int CONV_LIM = CONV_LIMIT_CYC;
	logic [DATA_W-1:0] wd_q;
	wire logic mux_wr = clk_en && reg_wr && reg_addr == OFS_MUXGAIN;
	wire logic clr_wr = clk_en && reg_wr && reg_addr == OFS_CLEAR;
	always_ff @(posedge sys_clk) wd_q <= reg_wdata;
	logic wait_on_r;
	logic [10:0] wait_cnt_r;
	// Launch-to-result span is too long for a delay range, so count it
	always_ff @(posedge sys_clk) begin
		if (srst || result_available_flag) begin
			wait_on_r <= 1'b0;
			wait_cnt_r <= 11'h000;
		end else if (conv_start) begin
			wait_on_r <= 1'b1;
			wait_cnt_r <= 11'h001;
		end else if (wait_on_r) begin
			wait_cnt_r <= wait_cnt_r + 11'h001;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	a_mux_write: assert property (mux_wr |=> gain_sel == wd_q[GAIN_HI:GAIN_LO]
		&& channel_sel == wd_q[CHAN_HI:0]) else $error("mux-gain write not taken");
	a_mux_hold: assert property (!mux_wr |=> $stable(gain_sel) && $stable(channel_sel))
		else $error("mux-gain changed without a write");
	a_start_single: assert property (conv_start |=> !conv_start)
		else $error("launch while converter busy");
	a_push_avail: assert property (clk_en && conv_done && !clr_wr |=> result_available_flag)
		else $error("finished result not stored");
	a_avail_deadline: assert property (wait_on_r |-> wait_cnt_r <= CONV_LIM)
		else $error("result late after launch");
	a_clear_empty: assert property (clr_wr && !conv_done |=> !result_available_flag)
		else $error("clear left results behind");
	a_flag_cause: assert property (!result_available_flag && !(clk_en && conv_done)
		|=> !result_available_flag) else $error("available flag without a result");
endmodule
bind adc_acquisition_control adc_acq_checker #(.FIFO_AW(FIFO_AW), .TB_DIV(TB_DIV)) i_chk(
	.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.external_convert_n(external_convert_n), .sequence_start_trigger_n(sequence_start_trigger_n),
	.pretrigger_stop_input(pretrigger_stop_input),
	.external_timebase_input(external_timebase_input), .gain_sel(gain_sel),
	.channel_sel(channel_sel), .conv_start(conv_start), .conv_done(conv_done),
	.conv_data(conv_data), .result_available_flag(result_available_flag));
`default_nettype wire

// >>> verif/conv_model.sv
// Converter model: answers each launch taken while idle after a short or long delay; launches while running are ignored.
// Assumes launches arrive as one-cycle pulses on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module conv_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic conv_start,
	input wire logic slow,
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic [11:0] code_r;
	logic [11:0] last_r;
	logic [10:0] cnt_r;
	logic run_r;
	// Idle data inverted so a late sample cannot pass by luck
	assign conv_data = conv_done ? last_r : ~last_r;
	always_ff @(posedge sys_clk) begin
		conv_done <= 1'b0;
		if (srst) begin
			run_r <= 1'b0;
			code_r <= 12'h5A5;
			last_r <= 12'h000;
		end else if (conv_start && !run_r) begin
			run_r <= 1'b1;
			last_r <= code_r;
			code_r <= code_r + 12'h123;
			cnt_r <= slow ? 11'h3E8 : 11'h003;
		end else if (run_r && cnt_r == 11'h000) begin
			run_r <= 1'b0;
			conv_done <= 1'b1;
		end else if (run_r) begin
			cnt_r <= cnt_r - 11'h001;
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Testbench: register-level tests of the acquisition control block.
// Assumes the converter model codes start at 5A5 and step by 123.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import acq_pkg::*;
	logic sys_clk, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, stop_in = 1'b0;
	logic ext_n = 1'b1, trig_n = 1'b1, tbsrc = 1'b0, conv_start, conv_done, flag;
	logic [3:0] reg_addr = 4'h0, chan;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic [1:0] gain;
	logic [11:0] conv_data, nxt = 12'h5A5;
	logic [3:0] ra[5] = '{OFS_CMD1, OFS_INTERVAL, OFS_COUNT_LO, OFS_COUNT_HI, 4'hF};
	logic [15:0] rv[5] = '{CMD1_RST, INTERVAL_RST, COUNT_RST, 16'h0000, 16'h0000};
	int n_fail = 0, num_checks = 0;
	adc_acquisition_control #(.TB_DIV(2)) i_adc_acquisition_control(
		.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_convert_n(ext_n), .sequence_start_trigger_n(trig_n),
		.pretrigger_stop_input(stop_in), .external_timebase_input(tbsrc), .gain_sel(gain),
		.channel_sel(chan), .conv_start(conv_start), .conv_done(conv_done),
		.conv_data(conv_data), .result_available_flag(flag));
	conv_model i_conv_model(.sys_clk(sys_clk), .srst(srst), .conv_start(conv_start),
		.slow(slow), .conv_done(conv_done), .conv_data(conv_data));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Free-running external timebase, one rising edge every two cycles
	always @(posedge sys_clk) tbsrc <= ~tbsrc;
	task automatic summarize();
		if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard, well past the longest path through the tests
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	function automatic logic [11:0] take();
		take = nxt;
		nxt = nxt + 12'h123;
	endfunction
	task automatic take_chk(string nm, logic sg);
		logic [11:0] c;
		d = 16'h0000;
		for (int i = 0; i < 800 && d[ST_AVAIL] !== 1'b1; i++) rd(OFS_STATUS);
		chk({nm, "_avail"}, 16'h2001, {2'b00, d[ST_AVAIL], 12'h000, flag});
		rd(OFS_FIFO);
		c = take();
		chk(nm, sg ? {{5{~c[11]}}, c[10:0]} : {4'h0, c}, d);
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		foreach (ra[j]) begin
			rd(ra[j]);
			chk("reset", rv[j], d);
		end
		wr(OFS_MUXGAIN, 16'h00F9);
		#1 chk("mux", 16'h0039, {10'h000, gain, chan});
		wr(OFS_CMD1, 16'h0002);
		for (int i = 0; i < 2; i++) begin
			slow <= i[0];
			wr(OFS_CONVERT, 16'h0000);
			take_chk("unsigned", 1'b0);
			rd(OFS_STATUS);
			chk("status", 16'h0000, d & 16'h3800);
		end
		chk("mux", 16'h0039, {10'h000, gain, chan});
		wr(OFS_CMD1, 16'h0000);
		wr(OFS_CONVERT, 16'h0000);
		take_chk("signed", 1'b1);
		@(posedge sys_clk);
		ext_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		ext_n <= 1'b1;
		take_chk("ext", 1'b1);
		wr(OFS_CMD1, 16'h0002);
		slow <= 1'b1;
		wr(OFS_CONVERT, 16'h0000);
		wr(OFS_CONVERT, 16'h0000);
		rd(OFS_STATUS);
		chk("overrun", 16'h0800, d & 16'h0800);
		take_chk("slow", 1'b0);
		wr(OFS_CLEAR, 16'h0000);
		rd(OFS_STATUS);
		chk("cleared", 16'h0000, d & 16'h3800);
		slow <= 1'b0;
		repeat (513) begin
			wr(OFS_CONVERT, 16'h0000);
			repeat (6) @(posedge sys_clk);
		end
		rd(OFS_STATUS);
		chk("overflow", 16'h3000, d & 16'h3000);
		rd(OFS_FIFO);
		chk("oldest", {4'h0, nxt}, d);
		repeat (513) void'(take());
		repeat (511) rd(OFS_FIFO);
		rd(OFS_STATUS);
		chk("drained", 16'h0000, d & 16'h2000);
		wr(OFS_CLEAR, 16'h0000);
		wr(OFS_START, 16'h0000);
		repeat (60) @(posedge sys_clk);
		rd(OFS_STATUS);
		chk("no_enable", 16'h0000, d & 16'h2200);
		wr(OFS_INTERVAL, 16'h0004);
		wr(OFS_COUNT_LO, 16'h0003);
		for (int t = 0; t < 3; t++) begin
			wr(OFS_CMD1, t == 1 ? 16'h0027 : (t == 2 ? 16'h000B : 16'h0003));
			@(posedge sys_clk);
			trig_n <= t[0] ? 1'b0 : 1'b1;
			if (t != 1) wr(OFS_START, 16'h0000);
			repeat (2) @(posedge sys_clk);
			trig_n <= 1'b1;
			repeat (t == 2 ? 3 : 0) begin
				repeat (10) @(posedge sys_clk);
				ext_n <= 1'b0;
				repeat (2) @(posedge sys_clk);
				ext_n <= 1'b1;
			end
			repeat (60) @(posedge sys_clk);
			rd(OFS_STATUS);
			chk("seq_end", 16'h0000, d & 16'h0200);
			repeat (3) take_chk("seq", 1'b0);
			rd(OFS_STATUS);
			chk("seq_count", 16'h0000, d & 16'h2000);
		end
		wr(OFS_CMD1, 16'h0013);
		wr(OFS_START, 16'h0000);
		repeat (60) @(posedge sys_clk);
		rd(OFS_STATUS);
		chk("pre_run", 16'h2200, d & 16'h2200);
		@(posedge sys_clk);
		stop_in <= 1'b1;
		repeat (60) @(posedge sys_clk);
		rd(OFS_STATUS);
		chk("pre_end", 16'h0000, d & 16'h0200);
		summarize();
	end
endmodule
`default_nettype wire
